// ==== inc/hai_pkg.sv ====
// Constants and types of the host access and interrupt logic
//
// Summary of operation
// - Mode pins 10 select first parallel bus
// - Mode pins 11 select alternate parallel bus
// - Mode pins 01 select the serial port
// - Serial word: command byte, then data byte
// - Flag 1 reads out, flag 0 writes
// - Pin mode picks open-drain or push-pull polarity
// - Global mask bit zero lets interrupts show
// - Events latch per bit, masked per bit
// - Rises always latch, edge select adds falls
// - Status read clears that channel flag
// - Pin drops once all pending acknowledged
// - Sixteen event kinds per channel
// - Live-status events have edge select bits
// - Any write to reset register resets device
// - Reset clears flops, registers, drivers off; masks load all ones
// - Global writes both channels, local one only
// - Copy bit broadcasts local writes
// - Channel two locals sit 0x20 higher
// - Mask 0 passes event, 1 suppresses
// - Status read clears its latched bits
package hai_pkg;
  // ----------------------------------------------------------
  // Register map
  // ----------------------------------------------------------
  localparam logic [5:0] ADDR_REV   = 6'h00;
  localparam logic [5:0] ADDR_RST   = 6'h01;
  localparam logic [5:0] ADDR_GCF   = 6'h20;
  localparam logic [5:0] ADDR_CHANNEL_IRQ_FLAGS = 6'h21;
  localparam int         CH_SEL_BIT = 5;
  localparam logic [4:0] LOC_FIRST  = 5'h02;
  localparam logic [4:0] LOC_TCF1   = 5'h05;
  localparam logic [4:0] LOC_MASK0  = 5'h13;
  localparam logic [4:0] LOC_MASK1  = 5'h14;
  localparam logic [4:0] LOC_IES    = 5'h15;
  localparam logic [4:0] LOC_LINE_CONDITION_BANK0  = 5'h16;
  localparam logic [4:0] LOC_LINE_CONDITION_BANK1  = 5'h17;
  localparam logic [4:0] LOC_EVENT_LATCH_BANK0  = 5'h18;
  localparam logic [4:0] LOC_EVENT_LATCH_BANK1  = 5'h19;
  localparam logic [4:0] LOC_CNT0   = 5'h1A;
  localparam logic [4:0] LOC_CNT1   = 5'h1B;
  localparam int         TCF1_THZ   = 4;
  // ----------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------
  localparam logic [7:0] GCF_RST  = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] IES_RST  = 8'h00;
  localparam logic [1:0] MODE_SER = 2'b01;
  localparam logic [1:0] MODE_PA  = 2'b10;
  localparam logic [1:0] MODE_PB  = 2'b11;
  localparam logic [1:0] PIN_PPL  = 2'b01;
  localparam logic [1:0] PIN_PPH  = 2'b10;
  localparam int         CMD_RW   = 0;
  localparam logic [4:0] SER_CMD_LAST = 5'd7;
  localparam logic [4:0] SER_LAST     = 5'd15;
  localparam logic [4:0] SER_END      = 5'd16;
  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_NS       = 40;
  localparam int SRST_MAX_NS  = 1000;
  localparam int SRST_MAX_CYC = SRST_MAX_NS / CLK_NS;
  localparam int HWRST_MIN_NS = 100;
  localparam int HWRST_MIN_CYC = (HWRST_MIN_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    HAI_HW, HAI_SER, HAI_PA, HAI_PB
  } hai_mode_t;
  typedef enum logic [3:0] {
    K_NONE, K_REV, K_RST, K_GCF, K_CHANNEL_IRQ_FLAGS, K_MEM, K_MASK0,
    K_MASK1, K_IES, K_LINE_CONDITION_BANK0, K_LINE_CONDITION_BANK1, K_EVENT_LATCH_BANK0, K_EVENT_LATCH_BANK1,
    K_CNT0, K_CNT1
  } hai_kind_t;
  typedef struct packed {
    logic [1:0] monitor;
    logic       spare;
    logic       t1e1;
    logic       copy;
    logic       gmask;
    logic [1:0] pin_mode;
  } hai_gcf_t;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } hai_req_t;
endpackage : hai_pkg

// ==== hw/hai_regbank.sv ====
// Banked local register storage with registered read data
`timescale 1ns/1ps
module hai_regbank #(
  parameter int AW    = 5,
  parameter int DW    = 8,
  parameter int BANKS = 2
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             clr_i,
  input  wire logic [BANKS-1:0] we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [DW-1:0]    wdata_i,
  input  wire logic             rbank_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [DW-1:0]    rdata_o
);
  typedef struct packed {
    logic [BANKS-1:0][2**AW-1:0][DW-1:0] mem;
    logic [DW-1:0]                       rdata;
  } hai_rb_state_t;

  hai_rb_state_t st_reg;
  hai_rb_state_t st_next;

  always_comb begin
    st_next = st_reg;
    for (int b = 0; b < BANKS; b++) begin
      if (we_i[b]) begin
        st_next.mem[b][waddr_i] = wdata_i;
      end
    end
    st_next.rdata = st_reg.mem[rbank_i][raddr_i];
    if (clr_i) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;
endmodule : hai_regbank

// ==== hw/hai_top.sv ====
// Host access port, register decode and interrupt aggregation
`timescale 1ns/1ps
module hai_top import hai_pkg::*; #(
  parameter logic [7:0] REVISION = 8'h00, // Arbitrary value
  parameter int         NCH      = 2
) (
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  input  wire logic [1:0]          mode_i,
  input  wire logic                cs_n_i,
  input  wire logic                sclk_i,
  input  wire logic                sdi_i,
  output logic                     sdo_o,
  output logic                     sdo_oe_o,
  input  wire logic [5:0]          addr_i,
  input  wire logic [7:0]          data_i,
  output logic      [7:0]          data_o,
  output logic                     data_oe_o,
  input  wire logic                ds_n_i,
  input  wire logic                rw_i,
  input  wire logic                rd_n_i,
  input  wire logic                wr_n_i,
  input  wire logic [NCH-1:0][7:0] line_condition_bank0_i,
  input  wire logic [NCH-1:0][5:0] line_condition_bank1_i,
  input  wire logic [NCH-1:0][7:0] event1_i,
  input  wire logic [NCH-1:0][15:0] cnt_i,
  output logic      [NCH-1:0]      drv_en_o,
  output logic                     irq_o,
  output logic                     irq_oe_o
);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  typedef struct packed {
    hai_mode_t           mode;
    logic                mode_ok;
    logic                sclk_prev;
    logic [4:0]          scnt;
    logic [7:0]          scmd;
    logic [7:0]          sdat;
    logic                ser_rd;
    logic                serial_data_out;
    logic                prd_prev;
    logic                pwr_prev;
    logic [1:0]          rd_pend;
    logic                rd_mem;
    logic [7:0]          rd_fast;
    logic [7:0]          rdata;
    hai_gcf_t            global_config;
    logic [NCH-1:0][7:0] mask0;
    logic [NCH-1:0][7:0] mask1;
    logic [NCH-1:0][7:0] ies;
    logic [NCH-1:0][7:0] event_latch_bank0;
    logic [NCH-1:0][7:0] event_latch_bank1;
    logic [NCH-1:0][7:0] stat_prev;
    logic [NCH-1:0]      chflag;
    logic [NCH-1:0]      drv_en;
    logic                srst;
  } hai_state_t;

  localparam hai_state_t ST_RST = '{
    mode: HAI_HW, global_config: GCF_RST, mask0: {NCH{MASK_RST}},
    mask1: {NCH{MASK_RST}}, ies: {NCH{IES_RST}}, default: '0};

  hai_state_t     st_reg;
  hai_state_t     st_next;
  hai_req_t       req;
  hai_kind_t      kind;
  logic           ch;
  logic [NCH-1:0] we;
  logic [7:0]     mem_rdata;
  logic           rd_act;
  logic           wr_act;
  logic           pending;

  // ----------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------
  function automatic hai_mode_t mode_dec(input logic [1:0] m);
    if (m == MODE_PA) begin
      return HAI_PA;
    end else if (m == MODE_PB) begin
      return HAI_PB;
    end else if (m == MODE_SER) begin
      return HAI_SER;
    end else begin
      return HAI_HW;
    end
  endfunction : mode_dec

  function automatic hai_kind_t kind_dec(input logic [5:0] a);
    logic [4:0] o;
    o = a[4:0];
    if (a == ADDR_REV) begin
      return K_REV;
    end else if (a == ADDR_RST) begin
      return K_RST;
    end else if (a == ADDR_GCF) begin
      return K_GCF;
    end else if (a == ADDR_CHANNEL_IRQ_FLAGS) begin
      return K_CHANNEL_IRQ_FLAGS;
    end else if (o < LOC_FIRST || o > LOC_CNT1) begin
      return K_NONE;
    end else if (o == LOC_MASK0) begin
      return K_MASK0;
    end else if (o == LOC_MASK1) begin
      return K_MASK1;
    end else if (o == LOC_IES) begin
      return K_IES;
    end else if (o == LOC_LINE_CONDITION_BANK0) begin
      return K_LINE_CONDITION_BANK0;
    end else if (o == LOC_LINE_CONDITION_BANK1) begin
      return K_LINE_CONDITION_BANK1;
    end else if (o == LOC_EVENT_LATCH_BANK0) begin
      return K_EVENT_LATCH_BANK0;
    end else if (o == LOC_EVENT_LATCH_BANK1) begin
      return K_EVENT_LATCH_BANK1;
    end else if (o == LOC_CNT0) begin
      return K_CNT0;
    end else if (o == LOC_CNT1) begin
      return K_CNT1;
    end else begin
      return K_MEM;
    end
  endfunction : kind_dec

  // ----------------------------------------------------------
  // Parallel strobes
  // ----------------------------------------------------------
  always_comb begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (st_reg.mode == HAI_PA) begin
      rd_act = !cs_n_i && !ds_n_i && rw_i;
      wr_act = !cs_n_i && !ds_n_i && !rw_i;
    end else if (st_reg.mode == HAI_PB) begin
      rd_act = !cs_n_i && !rd_n_i;
      wr_act = !cs_n_i && !wr_n_i;
    end
  end

  // ----------------------------------------------------------
  // Access sequencing and interrupt latching
  // ----------------------------------------------------------
  always_comb begin
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] set0;
    logic       clr0;
    logic       clr1;
    st_next = st_reg;
    req = '0;
    rise = '0;
    fall = '0;
    set0 = '0;
    clr0 = 1'b0;
    clr1 = 1'b0;
    if (!st_reg.mode_ok) begin
      st_next.mode = mode_dec(mode_i);
      st_next.mode_ok = 1'b1;
    end
    st_next.sclk_prev = sclk_i;
    if (st_reg.mode == HAI_SER) begin
      if (cs_n_i) begin
        st_next.scnt = '0;
        st_next.ser_rd = 1'b0;
      end else if (sclk_i && !st_reg.sclk_prev) begin
        if (st_reg.scnt <= SER_CMD_LAST) begin
          st_next.scmd[st_reg.scnt[2:0]] = sdi_i;
        end else begin
          st_next.sdat[st_reg.scnt[2:0]] = sdi_i;
        end
        if (st_reg.scnt == SER_CMD_LAST) begin
          st_next.ser_rd = st_reg.scmd[CMD_RW];
          req.rd = st_reg.scmd[CMD_RW];
          req.addr = st_reg.scmd[6:1];
        end
        if (st_reg.scnt == SER_LAST && !st_reg.ser_rd) begin
          req.wr = 1'b1;
          req.addr = st_reg.scmd[6:1];
          req.wdata = {sdi_i, st_reg.sdat[6:0]};
        end
        if (st_reg.scnt != SER_END) begin
          st_next.scnt = st_reg.scnt + 5'd1;
        end
      end else if (!sclk_i && st_reg.sclk_prev && st_reg.ser_rd
                   && st_reg.scnt > SER_CMD_LAST && st_reg.scnt < SER_END) begin
        st_next.serial_data_out = st_reg.rdata[st_reg.scnt[2:0]];
      end
    end
    st_next.prd_prev = rd_act;
    st_next.pwr_prev = wr_act;
    if (rd_act && !st_reg.prd_prev) begin
      req.rd = 1'b1;
      req.addr = addr_i;
    end else if (wr_act && !st_reg.pwr_prev) begin
      req.wr = 1'b1;
      req.addr = addr_i;
      req.wdata = data_i;
    end
    kind = kind_dec(req.addr);
    ch = req.addr[CH_SEL_BIT];
    if (st_reg.global_config.copy) begin
      we = {NCH{req.wr}};
    end else begin
      we = req.wr ? (NCH'(1) << ch) : '0;
    end
    if (req.wr) begin
      if (kind == K_GCF) begin
        st_next.global_config = req.wdata;
      end else if (kind == K_RST) begin
        st_next.srst = 1'b1;
      end
      for (int c = 0; c < NCH; c++) begin
        if (we[c] && kind == K_MASK0) begin
          st_next.mask0[c] = req.wdata;
        end else if (we[c] && kind == K_MASK1) begin
          st_next.mask1[c] = req.wdata;
        end else if (we[c] && kind == K_IES) begin
          st_next.ies[c] = req.wdata;
        end else if (we[c] && req.addr[4:0] == LOC_TCF1) begin
          st_next.drv_en[c] = !req.wdata[TCF1_THZ];
        end
      end
    end
    st_next.rd_pend = {st_reg.rd_pend[0], req.rd};
    st_next.rd_mem = (kind == K_MEM);
    if (req.rd) begin
      if (kind == K_REV) begin
        st_next.rd_fast = REVISION;
      end else if (kind == K_GCF) begin
        st_next.rd_fast = st_reg.global_config;
      end else if (kind == K_CHANNEL_IRQ_FLAGS) begin
        st_next.rd_fast = {6'h00, st_reg.chflag};
      end else if (kind == K_MASK0) begin
        st_next.rd_fast = st_reg.mask0[ch];
      end else if (kind == K_MASK1) begin
        st_next.rd_fast = st_reg.mask1[ch];
      end else if (kind == K_IES) begin
        st_next.rd_fast = st_reg.ies[ch];
      end else if (kind == K_LINE_CONDITION_BANK0) begin
        st_next.rd_fast = line_condition_bank0_i[ch];
      end else if (kind == K_LINE_CONDITION_BANK1) begin
        st_next.rd_fast = {2'b00, line_condition_bank1_i[ch]};
      end else if (kind == K_EVENT_LATCH_BANK0) begin
        st_next.rd_fast = st_reg.event_latch_bank0[ch];
      end else if (kind == K_EVENT_LATCH_BANK1) begin
        st_next.rd_fast = st_reg.event_latch_bank1[ch];
      end else if (kind == K_CNT0) begin
        st_next.rd_fast = cnt_i[ch][7:0];
      end else if (kind == K_CNT1) begin
        st_next.rd_fast = cnt_i[ch][15:8];
      end else begin
        st_next.rd_fast = 8'h00;
      end
    end
    if (st_reg.rd_pend[0]) begin
      st_next.rdata = st_reg.rd_mem ? mem_rdata : st_reg.rd_fast;
    end
    for (int c = 0; c < NCH; c++) begin
      rise = line_condition_bank0_i[c] & ~st_reg.stat_prev[c];
      fall = ~line_condition_bank0_i[c] & st_reg.stat_prev[c];
      set0 = rise | (st_reg.ies[c] & fall);
      clr0 = req.rd && kind == K_EVENT_LATCH_BANK0 && ch == c[0];
      clr1 = req.rd && kind == K_EVENT_LATCH_BANK1 && ch == c[0];
      st_next.stat_prev[c] = line_condition_bank0_i[c];
      st_next.event_latch_bank0[c] = set0 | (st_reg.event_latch_bank0[c] & ~{8{clr0}});
      st_next.event_latch_bank1[c] = event1_i[c] | (st_reg.event_latch_bank1[c] & ~{8{clr1}});
      st_next.chflag[c] = (|(set0 & ~st_reg.mask0[c]))
                        | (|(event1_i[c] & ~st_reg.mask1[c]))
                        | (st_reg.chflag[c] && !clr0 && !clr1);
    end
    if (st_reg.srst) begin
      st_next = ST_RST;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  hai_regbank #(.AW(5), .DW(8), .BANKS(NCH)) u_bank (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .clr_i    (st_reg.srst),
    .we_i     (kind == K_MEM ? we : '0),
    .waddr_i  (req.addr[4:0]),
    .wdata_i  (req.wdata),
    .rbank_i  (ch),
    .raddr_i  (req.addr[4:0]),
    .rdata_o  (mem_rdata)
  );

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  always_comb begin
    pending = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      pending = pending | (|(st_reg.event_latch_bank0[c] & ~st_reg.mask0[c]))
                        | (|(st_reg.event_latch_bank1[c] & ~st_reg.mask1[c]));
    end
    pending = pending && !st_reg.global_config.gmask;
    if (!st_reg.global_config.pin_mode[0] && st_reg.global_config.pin_mode != PIN_PPH) begin
      irq_o = 1'b0;
      irq_oe_o = pending;
    end else if (st_reg.global_config.pin_mode == PIN_PPH) begin
      irq_o = pending;
      irq_oe_o = 1'b1;
    end else begin
      irq_o = !pending;
      irq_oe_o = 1'b1;
    end
  end

  assign sdo_o = st_reg.serial_data_out;
  assign sdo_oe_o = st_reg.mode == HAI_SER && !cs_n_i && st_reg.ser_rd
                    && st_reg.scnt > SER_CMD_LAST;
  assign data_o = st_reg.rdata;
  assign data_oe_o = rd_act;
  assign drv_en_o = st_reg.drv_en;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  sequence s_rst_wr;
    req.wr && kind == K_RST;
  endsequence
  sequence s_rst_done;
    ##2 st_reg.global_config == GCF_RST && st_reg.chflag == '0;
  endsequence
  property p_srst;
    @(posedge clk_i) disable iff (!arst_n_i) s_rst_wr |-> s_rst_done;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset missed");
  property p_od;
    @(posedge clk_i) disable iff (!arst_n_i)
      st_reg.global_config.pin_mode == 2'b00 |-> !irq_o && irq_oe_o == pending;
  endproperty
  a_od: assert property (p_od) else $error("open drain wrong");
  property p_ppl;
    @(posedge clk_i) disable iff (!arst_n_i)
      st_reg.global_config.pin_mode == PIN_PPL |-> irq_oe_o && irq_o == !pending;
  endproperty
  a_ppl: assert property (p_ppl) else $error("push-pull low wrong");
  property p_gmask;
    @(posedge clk_i) disable iff (!arst_n_i)
      st_reg.global_config.gmask && st_reg.global_config.pin_mode == PIN_PPH |-> !irq_o;
  endproperty
  a_gmask: assert property (p_gmask) else $error("global mask leak");
  property p_rise;
    @(posedge clk_i) disable iff (!arst_n_i)
      line_condition_bank0_i[0][0] && !st_reg.stat_prev[0][0] && !st_reg.srst
      |-> ##1 st_reg.event_latch_bank0[0][0];
  endproperty
  a_rise: assert property (p_rise) else $error("rise not latched");
  property p_fall;
    @(posedge clk_i) disable iff (!arst_n_i)
      !line_condition_bank0_i[0][0] && st_reg.stat_prev[0][0] && !st_reg.ies[0][0]
      && !st_reg.event_latch_bank0[0][0] |-> ##1 !st_reg.event_latch_bank0[0][0];
  endproperty
  a_fall: assert property (p_fall) else $error("fall latched");
  property p_rdclr;
    @(posedge clk_i) disable iff (!arst_n_i)
      req.rd && kind == K_EVENT_LATCH_BANK1 && !ch && event1_i[0] == '0 && !st_reg.srst
      |-> ##1 st_reg.event_latch_bank1[0] == '0 ##1 data_o == $past(st_reg.event_latch_bank1[0], 2);
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("read clear wrong");
  property p_bcast;
    @(posedge clk_i) disable iff (!arst_n_i)
      req.wr && kind == K_MASK0 && st_reg.global_config.copy && !st_reg.srst
      |-> ##1 st_reg.mask0[0] == $past(req.wdata) && st_reg.mask0[1] == $past(req.wdata);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast missed");
  property p_serwr;
    @(posedge clk_i) disable iff (!arst_n_i)
      st_reg.mode == HAI_SER && req.wr |-> st_reg.scnt == SER_LAST && !st_reg.ser_rd;
  endproperty
  a_serwr: assert property (p_serwr) else $error("serial write early");
endmodule : hai_top

// ==== verif/hai_host.sv ====
// Host controller model for the serial and parallel register ports
`timescale 1ns/1ps
module hai_host (
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       sdo_i,
  input  wire logic       oe_i,
  output logic            cs_n_o,
  output logic            sclk_o,
  output logic            sdi_o,
  output logic            ds_n_o,
  output logic            rw_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic [5:0]      addr_o,
  output logic [7:0]      wdata_o
);
  // ----------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------
  initial begin
    cs_n_o  = 1'b1;
    sclk_o  = 1'b0;
    sdi_o   = 1'b0;
    ds_n_o  = 1'b1;
    rw_o    = 1'b1;
    rd_n_o  = 1'b1;
    wr_n_o  = 1'b1;
    addr_o  = 6'h00;
    wdata_o = 8'h00;
  end
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [15:0] w;
    w = {wd, 1'b0, a, rd};
    q = 8'h00;
    cs_n_o <= 1'b0;
    if (mode_i == 2'b01) begin
      for (int i = 0; i < 16; i++) begin
        sclk_o <= 1'b0;
        sdi_o  <= w[i];
        repeat (6) @(posedge clk_i);
        // Undriven bus reads back inverted
        if (i > 7) q[i-8] = oe_i ? sdo_i : ~sdo_i;
        sclk_o <= 1'b1;
        repeat (6) @(posedge clk_i);
      end
      sclk_o <= 1'b0;
      sdi_o  <= ~w[15];
    end else begin
      addr_o  <= a;
      wdata_o <= wd;
      if (mode_i[0]) begin
        rd_n_o <= ~rd;
        wr_n_o <= rd;
      end else begin
        ds_n_o <= 1'b0;
        rw_o   <= rd;
      end
      repeat (4) @(posedge clk_i);
      q = oe_i ? rdata_i : ~rdata_i;
      ds_n_o  <= 1'b1;
      rd_n_o  <= 1'b1;
      wr_n_o  <= 1'b1;
      wdata_o <= ~wd;
    end
    cs_n_o <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : xfer
endmodule : hai_host

// ==== verif/host_access_interrupt_logic_bench.sv ====
// Self-checking bench of the host access and interrupt logic
`timescale 1ns/1ps
module host_access_interrupt_logic_bench;
  import hai_pkg::*;
  logic             clk_i = 1'b0;
  logic             arst_n_i = 1'b0;
  logic [1:0]       mode_i = 2'b11;
  logic             cs_n, sclk, serial_data_in, serial_data_out, ds_n, rw, rd_n, wr_n, irq_o, irq_oe_o;
  logic             sdo_oe, data_oe;
  logic [5:0]       addr;
  logic [7:0]       wdata, rdata;
  logic [1:0][7:0]  line_condition_bank0 = '0;
  logic [1:0][7:0]  event1 = '0;
  logic [1:0][5:0]  line_condition_bank1 = {6'h2A, 6'h15};
  logic [1:0][15:0] cnt = {16'hABCD, 16'h1234};
  logic [1:0]       drv_en;
  int               err_total = 0;
  int               check_count = 0;
  always #20 clk_i = ~clk_i;
  hai_top #(.REVISION(8'h5A), .NCH(2)) dut ( // Arbitrary revision value
    .clk_i(clk_i), .arst_n_i(arst_n_i), .mode_i(mode_i), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(serial_data_in),
    .sdo_o(serial_data_out), .sdo_oe_o(sdo_oe), .addr_i(addr), .data_i(wdata), .data_o(rdata), .data_oe_o(data_oe),
    .ds_n_i(ds_n), .rw_i(rw), .rd_n_i(rd_n), .wr_n_i(wr_n), .line_condition_bank0_i(line_condition_bank0), .line_condition_bank1_i(line_condition_bank1),
    .event1_i(event1), .cnt_i(cnt), .drv_en_o(drv_en), .irq_o(irq_o), .irq_oe_o(irq_oe_o));
  hai_host host (
    .clk_i(clk_i), .mode_i(mode_i), .rdata_i(rdata), .sdo_i(serial_data_out), .oe_i(sdo_oe | data_oe),
    .cs_n_o(cs_n), .sclk_o(sclk),
    .sdi_o(serial_data_in), .ds_n_o(ds_n), .rw_o(rw), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_clk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b0, a, d, q);
  endtask : wr
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(1'b1, a, 8'h00, q);
    chk(q, e);
  endtask : rc
  task automatic pin_chk(input logic [1:0] pm, input logic act);
    logic [7:0] e;
    case (pm)
      2'b00: e = {6'h00, act, 1'b0};
      2'b10: e = {6'h00, 1'b1, act};
      default: e = {6'h00, 1'b1, ~act};
    endcase
    chk({6'h00, irq_oe_o, irq_oe_o & irq_o}, e);
  endtask : pin_chk
  task automatic set_los(input logic v);
    line_condition_bank0[0][0] <= v;
    wait_clk(3);
  endtask : set_los
  task automatic pulse_timer;
    event1 <= {2{8'h02}};
    wait_clk(1);
    event1 <= '0;
    wait_clk(2);
  endtask : pulse_timer
  task automatic hw_reset(input logic [1:0] m);
    mode_i   <= m;
    arst_n_i <= 1'b0;
    wait_clk(3);
    arst_n_i <= 1'b1;
    wait_clk(3);
  endtask : hw_reset
  task automatic t_defaults;
    hw_reset(MODE_PB);
    rc(ADDR_REV, 8'h5A);
    rc(ADDR_GCF, GCF_RST);
    rc(6'h13, MASK_RST);
    rc(6'h35, IES_RST);
    rc(6'h17, 8'h15);
    rc(6'h1A, 8'h34);
    rc(6'h3B, 8'hAB);
    rc(6'h1C, 8'h00);
    wr(ADDR_CHANNEL_IRQ_FLAGS, 8'hFF);
    rc(ADDR_CHANNEL_IRQ_FLAGS, 8'h00);
    chk({6'h00, drv_en}, 8'h00);
    pin_chk(2'b00, 1'b0);
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_irq;
    wr(6'h13, 8'hFE);
    set_los(1'b1);
    rc(ADDR_CHANNEL_IRQ_FLAGS, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_GCF, {6'h00, i[1:0]});
      pin_chk(i[1:0], 1'b1);
    end
    wr(ADDR_GCF, 8'h05);
    pin_chk(2'b01, 1'b0);
    wr(ADDR_GCF, 8'h06);
    pin_chk(2'b10, 1'b0);
    wr(ADDR_GCF, 8'h01);
    pulse_timer();
    rc(ADDR_CHANNEL_IRQ_FLAGS, 8'h01);
    rc(6'h39, 8'h02);
    wr(6'h34, 8'hFD);
    pulse_timer();
    rc(ADDR_CHANNEL_IRQ_FLAGS, 8'h03);
    rc(6'h18, 8'h01);
    rc(6'h19, 8'h02);
    rc(ADDR_CHANNEL_IRQ_FLAGS, 8'h02);
    pin_chk(2'b01, 1'b1);
    rc(6'h39, 8'h02);
    rc(ADDR_CHANNEL_IRQ_FLAGS, 8'h00);
    pin_chk(2'b01, 1'b0);
    set_los(1'b0);
    rc(6'h18, 8'h00);
    set_los(1'b1);
    rc(6'h18, 8'h01);
    wr(6'h15, 8'h01);
    set_los(1'b0);
    rc(6'h18, 8'h01);
    $display("test interrupts done");
  endtask : t_irq
  task automatic t_copy;
    wr(ADDR_GCF, 8'h08);
    wr(6'h02, 8'h15);
    wr(6'h13, 8'hF0);
    rc(6'h33, 8'hF0);
    rc(6'h22, 8'h15);
    wr(ADDR_GCF, 8'h00);
    wr(6'h22, 8'h2A);
    rc(6'h02, 8'h15);
    rc(6'h22, 8'h2A);
    wr(6'h05, 8'h00);
    chk({6'h00, drv_en}, 8'h01);
    $display("test broadcast done");
  endtask : t_copy
  task automatic t_srst;
    wr(ADDR_GCF, 8'h0B);
    wr(ADDR_RST, 8'h5A);
    wait_clk(SRST_MAX_CYC);
    rc(ADDR_GCF, GCF_RST);
    rc(6'h02, 8'h00);
    rc(6'h13, MASK_RST);
    chk({6'h00, drv_en}, 8'h00);
    $display("test soft reset done");
  endtask : t_srst
  task automatic t_serial;
    hw_reset(MODE_SER);
    wr(6'h22, 8'hC3);
    rc(6'h22, 8'hC3);
    rc(6'h02, 8'h00);
    rc(ADDR_REV, 8'h5A);
    $display("test serial done");
  endtask : t_serial
  task automatic t_mode_a;
    hw_reset(MODE_PA);
    wr(6'h03, 8'h3C);
    rc(6'h03, 8'h3C);
    rc(6'h23, 8'h00);
    hw_reset(2'b00);
    rc(ADDR_REV, 8'hFF);
    $display("test parallel a done");
  endtask : t_mode_a
  task automatic stop_test;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    wait_clk(1);
    t_defaults();
    t_irq();
    t_copy();
    t_srst();
    t_serial();
    t_mode_a();
    stop_test();
  end
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
endmodule : host_access_interrupt_logic_bench
